/* logic/msd_defines.svh */
// Address, region and step constants for the memory space access decoder
`ifndef MSD_DEFINES_SVH
`define MSD_DEFINES_SVH

// ----------------------------------------------------------------------
// Program space
// ----------------------------------------------------------------------
`define MSD_PA_W        24
`define MSD_PC_W        23
`define MSD_RESET_PC    23'h000000
`define MSD_START_SLOT  24'h000002
`define MSD_VEC0_BASE   24'h000004
`define MSD_VEC0_END    24'h0000FF
`define MSD_VEC1_BASE   24'h000100
`define MSD_VEC1_END    24'h0001FF
`define MSD_USER_BIT    23
`define MSD_PAGE_CFG    7
`define MSD_PC_STEP     23'h000002

// ----------------------------------------------------------------------
// Data space
// ----------------------------------------------------------------------
`define MSD_EA_W        16
`define MSD_EA_TOP      15
`define MSD_SFR_TOP     16'h07FF
`define MSD_NEAR_TOP    16'h1FFF
`define MSD_NEAR_W      13
`define MSD_RAM_BYTES   30720
`define MSD_BYTE_STEP   16'h0001
`define MSD_WORD_STEP   16'h0002
`define MSD_NREGS       16

`endif

/* logic/msd_pkg.sv */
// Types shared by the memory space access decoder
package msd_pkg;
  // Effective address formation modes
  typedef enum logic [1:0] {
    MSD_AM_INDIRECT,
    MSD_AM_DIRECT16,
    MSD_AM_NEAR13
  } msd_amode_e;

  // Data space regions
  typedef enum logic [1:0] {
    MSD_RG_SFR,
    MSD_RG_RAM,
    MSD_RG_UNIMPL,
    MSD_RG_PSV
  } msd_region_e;

  // Outstanding program bus access
  typedef enum logic [2:0] {
    MSD_PK_NONE,
    MSD_PK_FETCH,
    MSD_PK_VEC,
    MSD_PK_TABLE,
    MSD_PK_PSV
  } msd_pkind_e;
endpackage

/* logic/msd_lane_if.sv */
// Byte lane signals between the decoder and its lane steering unit
`timescale 1ns/1ps
interface msd_lane_if;
  logic [15:0] rd_word;  // Raw read word
  logic        rd_sel;   // Odd byte selected
  logic        rd_byte;  // Byte read
  logic        rd_zero;  // Force zero
  logic [15:0] rd_lane;  // Steered read data
  logic [15:0] wr_data;  // Raw write data
  logic        wr_sel;   // Odd byte targeted
  logic        wr_byte;  // Byte write
  logic        wr_kill;  // Store suppressed
  logic [1:0]  wr_be;    // Byte strobes
  logic [15:0] wr_lane;  // Write data on lanes

  modport core (output rd_word, rd_sel, rd_byte, rd_zero, wr_data, wr_sel, wr_byte, wr_kill,
                input rd_lane, wr_be, wr_lane);
  modport lane (input rd_word, rd_sel, rd_byte, rd_zero, wr_data, wr_sel, wr_byte, wr_kill,
                output rd_lane, wr_be, wr_lane);
endinterface

/* logic/msd_byte_lane.sv */
// Byte lane steering for data reads and byte write strobes
`timescale 1ns/1ps
module msd_byte_lane (
  msd_lane_if.lane ln  // Lane signals
);
  // ----------------------------------------------------------------------
  // Read side
  // ----------------------------------------------------------------------
  // Chosen byte lands on the low lane; upper lane zero for bytes
  wire [7:0]  rd_pick = ln.rd_sel ? ln.rd_word[15:8] : ln.rd_word[7:0];
  wire [15:0] rd_fmt  = ln.rd_byte ? {8'h00, rd_pick} : ln.rd_word;
  assign ln.rd_lane = ln.rd_zero ? 16'h0000 : rd_fmt;

  // ----------------------------------------------------------------------
  // Write side
  // ----------------------------------------------------------------------
  // Shared word decode, one strobe per half
  wire [1:0] be_raw = ln.wr_byte ? (ln.wr_sel ? 2'b10 : 2'b01) : 2'b11;
  assign ln.wr_be   = ln.wr_kill ? 2'b00 : be_raw;
  // Byte data is copied to both lanes so either strobe finds it
  assign ln.wr_lane = ln.wr_byte ? {ln.wr_data[7:0], ln.wr_data[7:0]} : ln.wr_data;
endmodule

/* logic/msd_access_decode.sv */
// Program and data memory space access decoder with working registers
`timescale 1ns/1ps
`include "msd_defines.svh"

// Contract
// - Program addresses are 24 bits, from the 23-bit counter, vector slot, table or window.
// - User program access stays below 0x800000 except table ops with page bit 7.
// - Program location: lower word even, upper word odd, top byte unimplemented.
// - Program counter stays lower-word aligned and steps by two.
// - After reset the counter is 0x000000; start address slot is 0x000002.
// - Vector tables span 0x000004-0x0000FF and 0x000100-0x0001FF.
// - Data effective addresses are 16-bit byte addresses over 64 Kbytes.
// - Address top bit clear selects data memory, set selects program window.
// - Reads beyond implemented data memory return zero.
// - Low byte at even address, high byte at odd address.
// - Post-modified pointers step by one for bytes, two for words.
// - Byte reads fetch the word and return the chosen byte on the low lane.
// - Shared word decode, separate byte strobes; byte writes touch one half.
// - Misaligned word access traps; read completes, write store suppressed.
// - Byte loads into a working register change only its low byte.
// - Addresses 0x0000-0x07FF decode to the control register region.
// - Unused control register addresses read zero.
// - Near addresses 0x0000-0x1FFF reachable by a 13-bit direct field.
// - Whole data space reachable by 16-bit direct or register indirect.
// - Separate read and write address generation paths.
module msd_access_decode
  import msd_pkg::*;
#(
  parameter int RAM_BYTES = `MSD_RAM_BYTES  // Implemented data memory bytes
) (
  input  wire logic        clk_in,                // Core clock
  input  wire logic        rst_n_in,              // Async reset, active low
  input  wire logic        fetch_req_in,          // Fetch and advance counter
  input  wire logic        pc_dec_in,             // Step counter back
  input  wire logic        jump_in,               // Load counter
  input  wire logic [23:0] jump_target_in,        // Jump target
  input  wire logic        vec_req_in,            // Vector fetch
  input  wire logic        vec_alt_in,            // Use second table
  input  wire logic [6:0]  vec_idx_in,            // Vector slot index
  input  wire logic        tbl_req_in,            // Table access
  input  wire logic        tbl_write_in,          // Table write, else read
  input  wire logic [7:0]  table_page_select_in,  // Table page
  input  wire logic [15:0] tbl_offset_in,         // Table offset
  input  wire logic [15:0] tbl_wdata_in,          // Table write data
  input  wire logic [7:0]  psv_page_in,           // Window page
  input  wire logic [23:0] prog_rdata_in,         // Program read data
  input  wire logic        rd_req_in,             // Data read
  input  wire msd_amode_e  rd_mode_in,            // Read address mode
  input  wire logic [15:0] rd_ptr_in,             // Read pointer
  input  wire logic [15:0] rd_field_in,           // Read direct field
  input  wire logic        rd_byte_in,            // Byte read
  input  wire logic        rd_post_inc_in,        // Post-increment read pointer
  input  wire logic [3:0]  rd_dest_in,            // Destination register
  input  wire logic        wr_req_in,             // Data write
  input  wire msd_amode_e  wr_mode_in,            // Write address mode
  input  wire logic [15:0] wr_ptr_in,             // Write pointer
  input  wire logic [15:0] wr_field_in,           // Write direct field
  input  wire logic        wr_byte_in,            // Byte write
  input  wire logic        wr_post_inc_in,        // Post-increment write pointer
  input  wire logic [15:0] wr_data_in,            // Write data
  input  wire logic [15:0] mem_rdata_in,          // Data memory read word
  input  wire logic        sfr_hit_in,            // Control register present
  input  wire logic [3:0]  wreg_sel_in,           // Register read select
  output logic      [23:0] program_counter_out,   // Program counter
  output logic      [23:0] prog_addr_out,         // Program bus address
  output logic             prog_rd_out,           // Program read strobe
  output logic             prog_wr_out,           // Program write strobe
  output logic      [23:0] prog_wdata_out,        // Program write data
  output logic      [23:0] prog_data_out,         // Program read result
  output logic             prog_valid_out,        // Program result valid
  output logic             prog_fault_out,        // Program access refused
  output logic             prog_stall_out,        // Program request dropped
  output logic             mem_rd_out,            // Data read strobe
  output logic      [15:0] mem_rd_addr_out,       // Data read word address
  output logic      [15:0] mem_wr_addr_out,       // Data write word address
  output logic      [1:0]  mem_be_out,            // Data byte strobes
  output logic      [15:0] mem_wdata_out,         // Data write word
  output logic      [15:0] rd_data_out,           // Read result
  output logic             rd_valid_out,          // Read result valid
  output logic      [15:0] rd_ptr_next_out,       // Updated read pointer
  output logic      [15:0] wr_ptr_next_out,       // Updated write pointer
  output logic             addr_err_out,          // Address error trap
  output logic      [15:0] wreg_rdata_out         // Register read data
);
  localparam logic [16:0] RAM_LIM = 17'(RAM_BYTES);

  // ----------------------------------------------------------------------
  // Address helpers
  // ----------------------------------------------------------------------
  // Effective address from mode, pointer and direct field
  function automatic logic [15:0] form_ea(msd_amode_e m, logic [15:0] p, logic [15:0] f);
    unique case (m)
      MSD_AM_INDIRECT: form_ea = p;
      MSD_AM_DIRECT16: form_ea = f;
      MSD_AM_NEAR13:   form_ea = {3'h0, f[`MSD_NEAR_W-1:0]};
      default:         form_ea = p;
    endcase
  endfunction

  // Region of a byte address
  function automatic msd_region_e region(logic [15:0] ea);
    if (ea[`MSD_EA_TOP])                 region = MSD_RG_PSV;
    else if (ea <= `MSD_SFR_TOP)         region = MSD_RG_SFR;
    else if ({1'b0, ea} < RAM_LIM)       region = MSD_RG_RAM;
    else                                 region = MSD_RG_UNIMPL;
  endfunction

  // Post-modify scaled by operand size
  function automatic logic [15:0] step(logic [15:0] p, logic is_byte, logic inc);
    if (!inc)         step = p;
    else if (is_byte) step = p + `MSD_BYTE_STEP;
    else              step = p + `MSD_WORD_STEP;
  endfunction

  // ----------------------------------------------------------------------
  // Data address generation, one path per direction
  // ----------------------------------------------------------------------
  wire [15:0]  rd_ea  = form_ea(rd_mode_in, rd_ptr_in, rd_field_in);
  wire [15:0]  wr_ea  = form_ea(wr_mode_in, wr_ptr_in, wr_field_in);
  msd_region_e rd_rg, wr_rg;
  assign rd_rg = region(rd_ea);
  assign wr_rg = region(wr_ea);
  wire rd_mis = rd_req_in && !rd_byte_in && rd_ea[0];
  wire wr_mis = wr_req_in && !wr_byte_in && wr_ea[0];
  wire rd_psv = rd_req_in && (rd_rg == MSD_RG_PSV);

  // ----------------------------------------------------------------------
  // Program bus arbitration
  // ----------------------------------------------------------------------
  logic [22:0] pc_reg, pc_next;
  msd_pkind_e  pk_reg, pk_next;
  logic        moved_reg;
  wire busy     = (pk_reg == MSD_PK_VEC);
  wire bus_vec  = vec_req_in && !rd_psv;
  wire bus_tbl  = tbl_req_in && !rd_psv && !vec_req_in;
  wire bus_ftch = fetch_req_in && !rd_psv && !vec_req_in && !tbl_req_in && !jump_in && !busy;
  wire [23:0] vec_base = vec_alt_in ? `MSD_VEC1_BASE : `MSD_VEC0_BASE;
  wire [23:0] vec_slot = vec_base + {16'h0000, vec_idx_in, 1'b0};
  wire        vec_ok   = vec_slot <= (vec_alt_in ? `MSD_VEC1_END : `MSD_VEC0_END);
  wire [23:0] tbl_addr = {table_page_select_in, tbl_offset_in};
  wire        tbl_ok   = !tbl_addr[`MSD_USER_BIT] || table_page_select_in[`MSD_PAGE_CFG];
  wire [23:0] psv_addr = {1'b0, psv_page_in, rd_ea[14:0]};
  wire [23:0] pc_addr  = {1'b0, pc_reg};
  wire        issue    = rd_psv || bus_vec || bus_tbl || bus_ftch;
  wire        refuse   = (bus_vec && !vec_ok) || (bus_tbl && !tbl_ok);
  wire [23:0] sel_addr = rd_psv ? psv_addr : bus_vec ? vec_slot : bus_tbl ? tbl_addr : pc_addr;
  wire        stall    = (fetch_req_in && !bus_ftch) || (tbl_req_in && !bus_tbl)
                         || (vec_req_in && !bus_vec) || (busy && (jump_in || pc_dec_in));

  // Kind of access whose data returns next cycle
  always_comb begin
    pk_next = MSD_PK_NONE;
    if (rd_psv)                 pk_next = MSD_PK_PSV;
    else if (bus_vec && vec_ok) pk_next = MSD_PK_VEC;
    else if (bus_tbl && tbl_ok && !tbl_write_in) pk_next = MSD_PK_TABLE;
    else if (bus_ftch)          pk_next = MSD_PK_FETCH;
  end

  // Counter: vector return beats jump beats fetch beats step back
  always_comb begin
    pc_next = pc_reg;
    if (busy)                   pc_next = {prog_rdata_in[22:1], 1'b0};
    else if (jump_in)           pc_next = {jump_target_in[22:1], 1'b0};
    else if (bus_ftch)          pc_next = pc_reg + `MSD_PC_STEP;
    else if (pc_dec_in)         pc_next = pc_reg - `MSD_PC_STEP;
  end

  // Odd program address returns the upper word with its top byte zero
  wire [23:0] prog_word = prog_addr_out[0] ? {16'h0000, prog_rdata_in[23:16]}
                                           : {8'h00, prog_rdata_in[15:0]};
  wire [23:0] tbl_wfmt  = tbl_offset_in[0] ? {8'h00, 8'h00, tbl_wdata_in[7:0]} << 16
                                           : {8'h00, tbl_wdata_in};

  // Program side registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pc_reg         <= `MSD_RESET_PC;
      pk_reg         <= MSD_PK_NONE;
      moved_reg      <= 1'b0;
      prog_addr_out  <= 24'h000000;
      prog_rd_out    <= 1'b0;
      prog_wr_out    <= 1'b0;
      prog_wdata_out <= 24'h000000;
      prog_data_out  <= 24'h000000;
      prog_valid_out <= 1'b0;
      prog_fault_out <= 1'b0;
      prog_stall_out <= 1'b0;
    end else begin
      pc_reg         <= pc_next;
      pk_reg         <= pk_next;
      moved_reg      <= moved_reg || (pc_next != pc_reg);
      if (issue) prog_addr_out <= sel_addr;
      prog_rd_out    <= issue && !refuse && !(bus_tbl && tbl_write_in);
      prog_wr_out    <= bus_tbl && tbl_write_in && tbl_ok;
      prog_wdata_out <= tbl_wfmt;
      if (pk_reg == MSD_PK_FETCH)      prog_data_out <= prog_rdata_in;
      else if (pk_reg == MSD_PK_TABLE) prog_data_out <= prog_word;
      prog_valid_out <= (pk_reg == MSD_PK_FETCH) || (pk_reg == MSD_PK_TABLE);
      prog_fault_out <= refuse;
      prog_stall_out <= stall;
    end
  end
  assign program_counter_out = {1'b0, pc_reg};

  // ----------------------------------------------------------------------
  // Data access pipeline
  // ----------------------------------------------------------------------
  msd_lane_if  ln ();
  msd_byte_lane u_lane (.ln(ln));
  logic        rd_pend_reg, rd_byte_reg, rd_sel_reg;
  msd_region_e rd_rg_reg;
  logic [3:0]  rd_dest_reg;
  logic [15:0] wreg_q [`MSD_NREGS];

  // Read side of the lane unit sees the word returned this cycle
  assign ln.rd_word = (rd_rg_reg == MSD_RG_PSV) ? prog_word[15:0] : mem_rdata_in;
  assign ln.rd_sel  = rd_sel_reg;
  assign ln.rd_byte = rd_byte_reg;
  assign ln.rd_zero = (rd_rg_reg == MSD_RG_UNIMPL)
                      || ((rd_rg_reg == MSD_RG_SFR) && !sfr_hit_in);
  // Writes into the window or unimplemented space are dropped
  assign ln.wr_data = wr_data_in;
  assign ln.wr_sel  = wr_ea[0];
  assign ln.wr_byte = wr_byte_in;
  assign ln.wr_kill = wr_mis || (wr_rg == MSD_RG_PSV) || (wr_rg == MSD_RG_UNIMPL);

  // Address stage: strobes, pointers and trap
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_pend_reg     <= 1'b0;
      rd_byte_reg     <= 1'b0;
      rd_sel_reg      <= 1'b0;
      rd_rg_reg       <= MSD_RG_SFR;
      rd_dest_reg     <= 4'h0;
      mem_rd_out      <= 1'b0;
      mem_rd_addr_out <= 16'h0000;
      mem_wr_addr_out <= 16'h0000;
      mem_be_out      <= 2'b00;
      mem_wdata_out   <= 16'h0000;
      rd_ptr_next_out <= 16'h0000;
      wr_ptr_next_out <= 16'h0000;
      addr_err_out    <= 1'b0;
    end else begin
      rd_pend_reg     <= rd_req_in;
      rd_byte_reg     <= rd_byte_in;
      rd_sel_reg      <= rd_ea[0];
      rd_rg_reg       <= rd_rg;
      rd_dest_reg     <= rd_dest_in;
      mem_rd_out      <= rd_req_in && !rd_psv;
      if (rd_req_in) mem_rd_addr_out <= {rd_ea[15:1], 1'b0};
      if (wr_req_in) mem_wr_addr_out <= {wr_ea[15:1], 1'b0};
      mem_be_out      <= wr_req_in ? ln.wr_be : 2'b00;
      mem_wdata_out   <= ln.wr_lane;
      if (rd_req_in) rd_ptr_next_out <= step(rd_ptr_in, rd_byte_in, rd_post_inc_in);
      if (wr_req_in) wr_ptr_next_out <= step(wr_ptr_in, wr_byte_in, wr_post_inc_in);
      addr_err_out    <= rd_mis || wr_mis;
    end
  end

  // Result stage: data out and destination register load
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_out    <= 16'h0000;
      rd_valid_out   <= 1'b0;
      wreg_rdata_out <= 16'h0000;
      for (int i = 0; i < `MSD_NREGS; i++) wreg_q[i] <= 16'h0000;
    end else begin
      rd_valid_out   <= rd_pend_reg;
      wreg_rdata_out <= wreg_q[wreg_sel_in];
      if (rd_pend_reg) begin
        rd_data_out <= ln.rd_lane;
        // High byte kept on byte loads
        if (rd_byte_reg) wreg_q[rd_dest_reg][7:0] <= ln.rd_lane[7:0];
        else             wreg_q[rd_dest_reg]      <= ln.rd_lane;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_rd_unimpl;
    rd_req_in && (rd_rg == MSD_RG_UNIMPL);
  endsequence
  sequence s_rd_done_zero;
    ##2 (rd_valid_out && (rd_data_out == 16'h0000));
  endsequence

  AST_PC_ALIGN: assert property (program_counter_out[0] == 1'b0)
    else $error("program counter left word alignment");
  AST_PC_RESET: assert property (!moved_reg |-> program_counter_out == 24'h000000)
    else $error("counter not at reset vector");
  AST_FETCH_STEP: assert property (bus_ftch |=> pc_reg == $past(pc_reg) + 23'h000002)
    else $error("fetch did not advance counter by two");
  AST_USER_LIMIT: assert property ((prog_rd_out || prog_wr_out) && prog_addr_out[23]
                                   |-> $past(bus_tbl && table_page_select_in[7]))
    else $error("upper program half reached without table page");
  AST_UNIMPL_ZERO: assert property (s_rd_unimpl |-> s_rd_done_zero)
    else $error("unimplemented read not zero");
  AST_MISALIGN: assert property (rd_req_in && !rd_byte_in && rd_ea[0]
                                 |=> addr_err_out ##1 rd_valid_out)
    else $error("misaligned read did not trap and complete");
  AST_WR_SUPPRESS: assert property (wr_mis |=> mem_be_out == 2'b00 && addr_err_out)
    else $error("misaligned write was stored");
  AST_BYTE_STROBE: assert property (wr_req_in && wr_byte_in && (wr_rg == MSD_RG_RAM)
                                    |=> mem_be_out == ($past(wr_ea[0]) ? 2'b10 : 2'b01))
    else $error("byte write strobe on wrong half");
  AST_BYTE_LANE: assert property (rd_req_in && rd_byte_in
                                  |-> ##2 rd_data_out[15:8] == 8'h00)
    else $error("byte read not on low lane");
  AST_PTR_STEP: assert property (rd_req_in && rd_post_inc_in
                                 |=> rd_ptr_next_out == $past(rd_ptr_in)
                                     + ($past(rd_byte_in) ? 16'h0001 : 16'h0002))
    else $error("pointer step not scaled by size");
endmodule

/* sim/msd_core_model.sv */
// Memory responder standing where the core's memories face the decoder
`timescale 1ns/1ps
module msd_core_model (
  input  wire logic        mem_rd_out,       // Data read strobe
  input  wire logic [15:0] mem_rd_addr_out,  // Data word address
  input  wire logic        prog_rd_out,      // Program read strobe
  input  wire logic [23:0] prog_addr_out,    // Program address
  output logic      [15:0] mem_rdata_in,     // Data word
  output logic             sfr_hit_in,       // Register present
  output logic      [23:0] prog_rdata_in     // Program word
);
  // ----------------------------------------------------------------------
  // Read paths
  // ----------------------------------------------------------------------
  // Address-derived words; data word inverted and program word all ones when idle so stale data never matches
  logic [15:0] word_val;
  assign word_val      = {~mem_rd_addr_out[7:0], mem_rd_addr_out[7:0]};
  assign mem_rdata_in  = mem_rd_out ? word_val : ~word_val;
  assign sfr_hit_in    = mem_rd_addr_out != 16'h0100;  // One hole in register space
  assign prog_rdata_in = prog_rd_out ? {8'h00, prog_addr_out[15:0]} : 24'hFFFFFF;
endmodule

/* sim/memory_space_access_decode_bench.sv */
// Self-checking bench for the memory space access decoder
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module memory_space_access_decode_bench;
  import msd_pkg::*;
  typedef struct {logic w, b; logic [15:0] a, d; logic [1:0] be; logic e;} msd_row_s;
  logic clk_in = 0, rst_n_in = 0, fetch_req_in = 0, pc_dec_in = 0, jump_in = 0;
  logic vec_req_in = 0, vec_alt_in = 0, tbl_req_in = 0, tbl_write_in = 0;
  logic rd_req_in = 0, rd_byte_in = 0, rd_post_inc_in = 1, wr_req_in = 0;
  logic wr_byte_in = 0, wr_post_inc_in = 1, sfr_hit_in;
  logic [23:0] jump_target_in = 0, prog_rdata_in;
  logic [6:0]  vec_idx_in = 0;
  logic [7:0]  table_page_select_in = 0, psv_page_in = 0;
  logic [15:0] tbl_offset_in = 0, tbl_wdata_in = 0, rd_ptr_in = 0, rd_field_in = 0;
  logic [15:0] wr_ptr_in = 0, wr_field_in = 0, wr_data_in = 16'h1234, mem_rdata_in;
  logic [3:0]  rd_dest_in = 4'hF, wreg_sel_in = 4'hF;
  msd_amode_e  rd_mode_in = MSD_AM_INDIRECT, wr_mode_in = MSD_AM_INDIRECT;
  logic [23:0] program_counter_out, prog_addr_out, prog_wdata_out, prog_data_out;
  logic prog_rd_out, prog_wr_out, prog_valid_out, prog_fault_out, prog_stall_out;
  logic mem_rd_out, rd_valid_out, addr_err_out;
  logic [1:0]  mem_be_out;
  logic [15:0] mem_rd_addr_out, mem_wr_addr_out, mem_wdata_out, rd_data_out;
  logic [15:0] rd_ptr_next_out, wr_ptr_next_out, wreg_rdata_out;
  int fail_count = 0;
  int checked = 0;
  // Reads cover RAM, unimplemented, register hole, window and misalignment
  msd_row_s rows[11] = '{'{0,0,16'h0900,16'hFF00,0,0}, '{0,1,16'h0901,16'h00FF,0,0},
    '{0,1,16'h0902,16'h0002,0,0}, '{0,0,16'h7800,16'h0000,0,0},
    '{0,0,16'h0100,16'h0000,0,0}, '{0,0,16'h8004,16'h0004,0,0},
    '{0,0,16'h0903,16'hFD02,0,1},
    '{1,1,16'h0905,0,2'b10,0}, '{1,1,16'h0904,0,2'b01,0},
    '{1,0,16'h0905,0,2'b00,1}, '{1,0,16'h0904,0,2'b11,0}};

  msd_access_decode u_dut (.*);
  msd_core_model u_model (.*);

  always #4 clk_in = ~clk_in;

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic end_of_test;
    if (fail_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // One data access; reads also wait for the result cycle
  task automatic acc(msd_row_s r);
    @(negedge clk_in);
    if (r.w) begin
      {wr_req_in, wr_ptr_in, wr_byte_in} = {1'b1, r.a, r.b};
    end else begin
      {rd_req_in, rd_ptr_in, rd_byte_in} = {1'b1, r.a, r.b};
    end
    @(negedge clk_in);
    {wr_req_in, rd_req_in} = 2'b00;
    `CHK(addr_err_out, r.e)
    if (r.w) begin
      `CHK(mem_be_out, r.be)
      `CHK(mem_wr_addr_out, {r.a[15:1], 1'b0})
      `CHK(mem_wdata_out, r.b ? {2{wr_data_in[7:0]}} : wr_data_in)
      `CHK(wr_ptr_next_out, r.a + (r.b ? 16'h0001 : 16'h0002))
    end else begin
      `CHK(mem_rd_out, !r.a[15])
      `CHK(rd_ptr_next_out, r.a + (r.b ? 16'h0001 : 16'h0002))
      @(negedge clk_in);
      `CHK(rd_data_out, r.d)
      `CHK(rd_valid_out, 1'b1)
    end
  endtask

  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (10) @(negedge clk_in);
    rst_n_in = 1;
    `CHK(program_counter_out, 24'h000000)
    foreach (rows[i]) acc(rows[i]);
    // Byte load keeps the register's high byte from the misaligned word
    acc('{0, 1, 16'h0901, 16'h00FF, 2'b00, 0});
    @(negedge clk_in);
    `CHK(wreg_rdata_out, 16'hFDFF)
    // Near field picks 0x0904 while the pointer sits at zero
    rd_mode_in = MSD_AM_NEAR13;
    rd_field_in = 16'hE904;
    acc('{0, 0, 16'h0000, 16'hFB04, 2'b00, 0});
    rd_mode_in = MSD_AM_INDIRECT;
    wr_mode_in = MSD_AM_DIRECT16;
    wr_field_in = 16'h0A06;
    {wr_req_in, wr_ptr_in, wr_byte_in} = {1'b1, 16'h0002, 1'b0};
    @(negedge clk_in);
    wr_req_in = 0;
    `CHK(mem_wr_addr_out, 16'h0A06)
    `CHK(wr_ptr_next_out, 16'h0004)
    fetch_req_in = 1;
    @(negedge clk_in);
    fetch_req_in = 0;
    `CHK(prog_addr_out, 24'h000000)
    `CHK(program_counter_out, 24'h000002)
    {vec_req_in, vec_idx_in} = {1'b1, 7'h7F};
    @(negedge clk_in);
    vec_idx_in = 7'h00;
    `CHK(prog_fault_out, 1'b1)
    @(negedge clk_in);
    vec_req_in = 0;
    `CHK(prog_addr_out, 24'h000004)
    @(negedge clk_in);
    `CHK(program_counter_out, 24'h000004)
    {jump_in, jump_target_in} = {1'b1, 24'h000101};
    @(negedge clk_in);
    {jump_in, pc_dec_in} = 2'b01;
    `CHK(program_counter_out, 24'h000100)
    @(negedge clk_in);
    pc_dec_in = 0;
    `CHK(program_counter_out, 24'h0000FE)
    // Mid-run reset, then a request on the first edge after release
    rst_n_in = 0;
    @(negedge clk_in);
    `CHK(wreg_rdata_out, 16'h0000)
    `CHK(program_counter_out, 24'h000000)
    rst_n_in = 1;
    {tbl_req_in, tbl_offset_in, fetch_req_in} = {1'b1, 16'h0012, 1'b1};
    @(negedge clk_in);
    {tbl_req_in, fetch_req_in} = 2'b00;
    `CHK(prog_addr_out, 24'h000012)
    `CHK(prog_stall_out, 1'b1)
    @(negedge clk_in);
    `CHK(prog_data_out, 24'h000012)
    `CHK(prog_valid_out, 1'b1)
    {tbl_req_in, tbl_write_in, table_page_select_in} = {2'b11, 8'h80};
    {tbl_offset_in, tbl_wdata_in} = {16'h0001, 16'h00AB};
    @(negedge clk_in);
    {tbl_req_in, vec_req_in, vec_alt_in, vec_idx_in} = {3'b011, 7'h7F};
    `CHK(prog_wr_out, 1'b1)
    `CHK(prog_addr_out, 24'h800001)
    `CHK(prog_wdata_out, 24'hAB0000)
    @(negedge clk_in);
    vec_req_in = 0;
    `CHK(prog_addr_out, 24'h0001FE)
    `CHK(prog_fault_out, 1'b0)
    end_of_test;
  end

  // Hang guard, far beyond the few dozen cycles the tests need
  initial begin
    #(8 * 2000);
    fail_count++;
    end_of_test;
  end
endmodule
